/* shared/clps_consts.vh */
// clps_consts.vh: constants for the closed-loop profile store
// assumes a 100 MHz clock and a 32-bit classic wishbone slave port
`ifndef CLPS_CONSTS_VH
`define CLPS_CONSTS_VH
// per-slot parameter indices (word index within a slot)
`define CLPS_P_KP 4'h0
`define CLPS_P_KI 4'h1
`define CLPS_P_KD 4'h2
`define CLPS_P_KF 4'h3
`define CLPS_P_IZONE 4'h4
`define CLPS_P_ALLOW 4'h5
`define CLPS_P_PKFWD 4'h6
`define CLPS_P_PKREV 4'h7
`define CLPS_P_NMFWD 4'h8
`define CLPS_P_NMREV 4'h9
`define CLPS_P_RAMP 4'ha
`define CLPS_NPAR 4'hb
// register byte addresses
`define CLPS_A_PROF 8'h00
`define CLPS_A_CTRL 8'h80
`define CLPS_A_STAT 8'h84
`define CLPS_A_ERR 8'h88
`define CLPS_A_PID 8'h8c
`define CLPS_A_OUT 8'h90
`define CLPS_A_CLRAMP 8'h94
`define CLPS_A_OLRAMP 8'h98
// profile window: slot at bit 6, param index at bits 5:2
`define CLPS_PROF_TOP 8'h80
// output scale
`define CLPS_FULL 11'sh3ff
`define CLPS_PKFWD_RST 32'h0000_03ff
`define CLPS_PKREV_RST 32'hffff_fc01
// commit interval
`define CLPS_HOLD_S 15
`define CLPS_CLK_HZ 100000000
`define CLPS_HOLD_CYC (`CLPS_HOLD_S * `CLPS_CLK_HZ)
// flash record rotation
`define CLPS_NREC 2'h3
`endif

/* verilog/clps_flash.v */
// clps_flash.v: wear-levelled record store behind the profile store
// assumes flash contents survive reset; modelled by flip-flops not cleared by reset
`timescale 1ns/1ps
`include "clps_consts.vh"
module clps_flash #(
    parameter W = 704
) (
    input wire clk_i,
    input wire rst_i,
    input wire wr_i,
    input wire [W-1:0] data_i,
    output reg busy_o,
    output reg [W-1:0] data_o,
    output reg valid_o
);
    reg [W-1:0] rec_q [0:2];
    reg [7:0] seq_q [0:2];
    reg [2:0] ok_q = 3'h0; // erased at power-up; reset leaves records alone
    reg [1:0] wp_q;
    reg [7:0] nseq_q;
    reg [1:0] st_q;
    reg [1:0] i;
    reg [1:0] best;
    // newest intact record wins at power-up
    always @* begin
        best = 2'h0;
        for (i = 2'h0; i < `CLPS_NREC; i = i + 2'h1) begin
            if (ok_q[i] && (!ok_q[best] || (seq_q[i] - seq_q[best]) < 8'h80))
                best = i;
        end
    end
    always @(posedge clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            st_q <= 2'h0;
            valid_o <= 1'b0;
        end else if (st_q == 2'h0) begin
            // load after reset
            data_o <= rec_q[best];
            valid_o <= ok_q[best];
            wp_q <= (best == 2'h2) ? 2'h0 : best + 2'h1;
            nseq_q <= ok_q[best] ? seq_q[best] + 8'h01 : 8'h00; // empty store counts from zero
            st_q <= 2'h1;
        end else if (st_q == 2'h1) begin
            valid_o <= 1'b0;
            if (wr_i) begin
                // invalidate target first; a loss mid-write keeps older record
                ok_q[wp_q] <= 1'b0;
                rec_q[wp_q] <= data_i;
                seq_q[wp_q] <= nseq_q;
                busy_o <= 1'b1;
                st_q <= 2'h2;
            end
        end else begin
            ok_q[wp_q] <= 1'b1; // rotate locations
            wp_q <= (wp_q == 2'h2) ? 2'h0 : wp_q + 2'h1;
            nseq_q <= nseq_q + 8'h01;
            busy_o <= 1'b0;
            st_q <= 2'h1;
        end
    end
endmodule // clps_flash

/* verilog/clps_top.v */
// clps_top.v: closed-loop gain profile store and output shaper
// assumes a classic wishbone master; the pid math sits outside and feeds raw terms
// How it works
// - four gain profile slots with gains, zone, error and limits; only slots 0 and 1 are addressable and held persistently.
// - controller picks slot 0 or 1; only that slot shapes the output.
// - nonzero integral zone clears the accumulator when error exceeds it.
// - error below allowable error zeroes accumulator and pid output.
// - output capped at peak limit in each direction.
// - weak nonzero output promoted to the nominal limit.
// - any closed-loop mode may use either slot.
// - written parameters take effect at once.
// - with fifteen quiet seconds a change commits immediately.
// - otherwise commit waits fifteen seconds after the last commit.
// - history kept; power loss during commit restores prior values.
// - after reset the last committed parameters are loaded and used.
// - commit only when working copy differs from stored copy.
// - bus writes always override loaded values.
// - per-profile ramp field is ignored; separate ramp registers instead.
// - within allowable error the feed-forward term still applies.
// - accumulator cleared on mode change, disable, or slot change.
// - output is signed, -1023 to +1023.
//
// Local design decisions: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "clps_consts.vh"
module clps_top #(
    parameter HOLD_CYC = `CLPS_HOLD_CYC,
    parameter NSLOT = 4
) (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    input wire signed [31:0] err_i,
    input wire signed [31:0] pterm_i,
    input wire signed [31:0] iterm_i,
    input wire signed [31:0] dterm_i,
    input wire signed [31:0] fterm_i,
    input wire tick_i,
    output reg signed [10:0] out_o,
    output reg iacc_clr_o,
    output reg [1:0] slot_o,
    output reg [1:0] mode_o,
    output reg [11:0] clramp_o,
    output reg [11:0] olramp_o
);
    // persisted image width: two slots of eleven words
    localparam W = 32 * 11 * 2;
    // commit scheduler states
    localparam S_IDLE = 2'h0;
    localparam S_WAIT = 2'h1;
    localparam S_BUSY = 2'h2;
    // working copy of slots 0..3, flattened
    reg [31:0] par_q [0:NSLOT*11-1];
    reg [W-1:0] stored_q;
    reg [1:0] st_q;
    reg [31:0] tmr_q;
    reg quiet_q;
    reg fl_wr_q;
    reg loaded_q;
    reg en_q;
    reg [1:0] mode_q;
    reg [1:0] slot_q;
    reg [2:0] ctl_fb_q;
    reg boot_q;
    // record store handshake and image
    wire fl_busy;
    wire fl_valid;
    wire [W-1:0] fl_data;
    // flattened working image handed to the record store
    reg [W-1:0] work;
    // loop index for slot and image walks
    integer k;
    // byte-lane merge for writes
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] s;
        begin
            merge = {s[3] ? nw[31:24] : old[31:24], s[2] ? nw[23:16] : old[23:16],
                     s[1] ? nw[15:8] : old[15:8], s[0] ? nw[7:0] : old[7:0]};
        end
    endfunction
    // absolute value
    function [31:0] mag;
        input signed [31:0] v;
        begin
            mag = v[31] ? -v : v;
        end
    endfunction
    // index into working copy
    function [5:0] pidx;
        input [1:0] s;
        input [3:0] p;
        begin
            pidx = s * 6'd11 + {2'h0, p};
        end
    endfunction
    // bus decode: a request is taken once, while ack is low
    wire req = cyc_i & stb_i & ~ack_o;
    wire prof_hit = adr_i < `CLPS_PROF_TOP && adr_i[5:2] < `CLPS_NPAR;
    wire [5:0] widx = pidx({1'b0, adr_i[6]}, adr_i[5:2]);
    // persisted image: slots 0 and 1
    always @* begin
        work = {W{1'b0}};
        for (k = 0; k < 22; k = k + 1)
            work[k*32 +: 32] = par_q[k];
    end
    // working copy differs from the last committed image
    wire changed = (work != stored_q);
    // record store, persistent across reset
    clps_flash #(.W(W)) u_flash (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(fl_wr_q),
        .data_i(work),
        .busy_o(fl_busy),
        .data_o(fl_data),
        .valid_o(fl_valid)
    );
    // parameter store: bus writes win over loaded image
    always @(posedge clk_i) begin
        if (rst_i) begin
            for (k = 0; k < NSLOT*11; k = k + 1) begin
                par_q[k] <= 32'h0;
                if (k % 11 == `CLPS_P_PKFWD)
                    par_q[k] <= `CLPS_PKFWD_RST;
                if (k % 11 == `CLPS_P_PKREV)
                    par_q[k] <= `CLPS_PKREV_RST;
            end
            loaded_q <= 1'b0;
            boot_q <= 1'b0;
        end else begin
            // the record store offers its image on the first edge after reset; it is taken in on the second
            boot_q <= 1'b1;
            if (fl_valid && !loaded_q) begin
                for (k = 0; k < 22; k = k + 1)
                    par_q[k] <= fl_data[k*32 +: 32];
            end
            loaded_q <= boot_q; // load window closes after that edge
            if (req && we_i && prof_hit)
                par_q[widx] <= merge(par_q[widx], dat_i, sel_i);
        end
    end
    // commit scheduler with fifteen-second spacing
    always @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= S_IDLE;
            tmr_q <= 32'h0;
            quiet_q <= 1'b1;
            fl_wr_q <= 1'b0;
            stored_q <= {W{1'b0}};
        end else begin
            fl_wr_q <= 1'b0;
            if (tmr_q >= HOLD_CYC - 1)
                quiet_q <= 1'b1;
            else
                tmr_q <= tmr_q + 32'h1;
            if (fl_valid)
                stored_q <= fl_data;
            case (st_q)
                S_IDLE: begin
                    // no commit before the stored image has been taken in
                    if (changed && loaded_q && !fl_valid) begin
                        if (quiet_q) begin
                            fl_wr_q <= 1'b1;
                            stored_q <= work;
                            st_q <= S_BUSY;
                        end else begin
                            st_q <= S_WAIT;
                        end
                    end
                end
                S_WAIT: begin
                    if (!changed)
                        st_q <= S_IDLE;
                    else if (quiet_q) begin
                        fl_wr_q <= 1'b1;
                        stored_q <= work;
                        st_q <= S_BUSY;
                    end
                end
                S_BUSY: begin
                    if (!fl_wr_q && !fl_busy) begin
                        tmr_q <= 32'h0;
                        quiet_q <= 1'b0;
                        st_q <= S_IDLE;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end
    // ramp words after byte-lane merge; only the low twelve bits are kept
    wire [31:0] clramp_m = merge({20'h0, clramp_o}, dat_i, sel_i);
    wire [31:0] olramp_m = merge({20'h0, olramp_o}, dat_i, sel_i);
    // control registers supplied by the controller
    always @(posedge clk_i) begin
        if (rst_i) begin
            en_q <= 1'b0;
            mode_q <= 2'h0;
            slot_q <= 2'h0;
            ctl_fb_q <= 3'h0;
            clramp_o <= 12'h0;
            olramp_o <= 12'h0;
        end else if (req && we_i) begin
            // control word: enable, mode, slot and sensor flags
            if (adr_i == `CLPS_A_CTRL && sel_i[0]) begin
                en_q <= dat_i[0];
                mode_q <= dat_i[2:1]; // any mode, slot 0 or 1
                slot_q <= {1'b0, dat_i[3]};
                ctl_fb_q <= dat_i[6:4];
            end
            if (adr_i == `CLPS_A_CLRAMP)
                clramp_o <= clramp_m[11:0];
            if (adr_i == `CLPS_A_OLRAMP)
                olramp_o <= olramp_m[11:0];
        end
    end
    // active slot values
    wire signed [31:0] a_zone = par_q[pidx(slot_q, `CLPS_P_IZONE)];
    wire signed [31:0] a_allow = par_q[pidx(slot_q, `CLPS_P_ALLOW)];
    wire signed [31:0] a_pkf = par_q[pidx(slot_q, `CLPS_P_PKFWD)];
    wire signed [31:0] a_pkr = par_q[pidx(slot_q, `CLPS_P_PKREV)];
    wire signed [31:0] a_nmf = par_q[pidx(slot_q, `CLPS_P_NMFWD)];
    wire signed [31:0] a_nmr = par_q[pidx(slot_q, `CLPS_P_NMREV)];
    // error magnitude, allowable band and raw pid sum
    wire [31:0] emag = mag(err_i);
    wire in_allow = emag < a_allow;
    wire signed [31:0] pid_sum = pterm_i + iterm_i + dterm_i;
    reg signed [31:0] raw;
    reg signed [31:0] shp;
    // output shaping from the selected slot only
    always @* begin
        raw = in_allow ? fterm_i : pid_sum + fterm_i;
        shp = raw;
        if (raw > 0 && raw < a_nmf && !in_allow && err_i != 0)
            shp = a_nmf;
        if (raw < 0 && raw > a_nmr && !in_allow && err_i != 0)
            shp = a_nmr;
        if (shp > a_pkf)
            shp = a_pkf;
        if (shp < a_pkr)
            shp = a_pkr;
        // full scale after the slot limits, so no setting can wrap the eleven-bit output
        if (shp > $signed(`CLPS_PKFWD_RST))
            shp = $signed(`CLPS_PKFWD_RST);
        if (shp < $signed(`CLPS_PKREV_RST))
            shp = $signed(`CLPS_PKREV_RST);
        if (!en_q)
            shp = 32'sh0;
    end
    // output registers and accumulator clear
    always @(posedge clk_i) begin
        if (rst_i) begin
            out_o <= 11'sh0;
            iacc_clr_o <= 1'b1;
            slot_o <= 2'h0;
            mode_o <= 2'h0;
        end else begin
            slot_o <= slot_q;
            mode_o <= mode_q;
            // output moves only on the loop tick
            if (tick_i)
                out_o <= shp[10:0];
            // clear on zone, allowable band or a change of context
            iacc_clr_o <= (a_zone != 0 && emag > a_zone)
                || in_allow
                || !en_q || mode_o != mode_q || slot_o != slot_q;
        end
    end
    // wishbone: one-cycle ack, reads return state
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= req;
            // read mux, latched when the request is taken
            if (req && !we_i) begin
                if (prof_hit)
                    dat_o <= par_q[widx];
                else if (adr_i == `CLPS_A_CTRL)
                    dat_o <= {25'h0, ctl_fb_q, slot_q[0], mode_q, en_q};
                else if (adr_i == `CLPS_A_STAT)
                    dat_o <= {28'h0, quiet_q, changed, st_q};
                else if (adr_i == `CLPS_A_ERR)
                    dat_o <= err_i;
                else if (adr_i == `CLPS_A_OUT)
                    dat_o <= {{21{out_o[10]}}, out_o};
                else if (adr_i == `CLPS_A_CLRAMP)
                    dat_o <= {20'h0, clramp_o};
                else if (adr_i == `CLPS_A_OLRAMP)
                    dat_o <= {20'h0, olramp_o};
                else
                    dat_o <= 32'h0;
            end
        end
    end
endmodule // clps_top

/* verif/clps_ctl_model.sv */
// clps_ctl_model.sv: controller side model, a classic wishbone master
// assumes a slave that answers each request with one ack pulse
`timescale 1ns/1ps
`include "clps_consts.vh"
module clps_ctl_model (
    input wire clk_i,
    input wire ack_i,
    input wire [31:0] rdat_i,
    output reg cyc_o = 1'b0,
    output reg stb_o = 1'b0,
    output reg we_o = 1'b0,
    output reg [7:0] adr_o = 8'h00,
    output reg [3:0] sel_o = 4'h0,
    output reg [31:0] dat_o = 32'h0
);
    // one transfer: hold until ack, take data there, then release
    task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        sel_o <= s;
        dat_o <= d;
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = rdat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o <= 1'b0;
        adr_o <= ~a; // released address and data lines lose the old value
        dat_o <= ~d;
    endtask
    // enable, mode and slot sent before closed-loop use
    task automatic cfg(input logic e, input logic [1:0] m, input logic s);
        logic [31:0] q;
        xfer(1'b1, `CLPS_A_CTRL, 4'hf, {28'h0, s, m, e}, q);
    endtask
endmodule // clps_ctl_model

/* verif/clps_top_props.sv */
// clps_top_props.sv: bus and output checks on the profile store ports
// assumes a bind to clps_top; one clock, synchronous reset
`timescale 1ns/1ps
module clps_top_props (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    input wire tick_i,
    input wire signed [10:0] out_o,
    input wire iacc_clr_o,
    input wire [1:0] slot_o,
    input wire [1:0] mode_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // a taken request and its single-cycle answer
    sequence s_take;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_ans;
        ack_o ##1 !ack_o;
    endsequence
    a_ack_pulse: assert property (s_take |=> s_ans)
        else $error("ack missing or too long");
    a_ack_cause: assert property ($rose(ack_o) |-> $past(stb_i) && $past(cyc_i))
        else $error("ack without request");
    a_ack_idle: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack while idle");
    a_read_data: assert property ($changed(dat_o) |-> ack_o && !$past(we_i))
        else $error("read data moved outside a read");
    a_out_range: assert property (out_o != 11'h400)
        else $error("output beyond full scale");
    a_out_tick: assert property ($changed(out_o) |-> $past(tick_i) || $past(tick_i, 2))
        else $error("output moved without tick");
    a_slot_clr: assert property ($changed(slot_o) |-> ##[0:2] iacc_clr_o)
        else $error("slot change kept accumulator");
    a_mode_clr: assert property ($changed(mode_o) |-> ##[0:2] iacc_clr_o)
        else $error("mode change kept accumulator");
endmodule // clps_top_props

/* verif/clps_top_tb.sv */
// clps_top_tb.sv: self-checking bench for the profile store
// assumes the controller model drives the bus; commit hold cut to 50 cycles
`timescale 1ns/1ps
`include "clps_consts.vh"
module clps_top_tb;
    typedef struct packed {
        logic s;
        logic [1:0] m;
        logic [31:0] e;
        logic [31:0] p;
        logic [31:0] f;
        logic [10:0] o;
    } clps_row_t;
    // slot, mode, error, pid share, feed-forward, expected output
    clps_row_t rows [9] = '{
        '{1'h0, 2'h1, 32'h32, 32'hfa, 32'h32, 11'h12c},
        '{1'h0, 2'h1, 32'h32, 32'h384, 32'h0, 11'h258},
        '{1'h0, 2'h1, -32'h32, -32'h384, 32'h0, -11'h258},
        '{1'h0, 2'h1, 32'h32, 32'h28, 32'h0, 11'h64},
        '{1'h0, 2'h1, -32'h32, -32'h28, 32'h0, -11'h64},
        '{1'h0, 2'h1, 32'h2, 32'hc8, 32'h0, 11'h0},
        '{1'h0, 2'h1, 32'h2, 32'hc8, 32'h1e, 11'h1e},
        '{1'h1, 2'h1, 32'h32, 32'h12c, 32'h0, 11'hc8},
        '{1'h0, 2'h2, 32'h32, 32'h12c, 32'h0, 11'h12c}
    };
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic tick_i = 1'b0;
    logic signed [31:0] err_i = 32'h0, pterm_i = 32'h0, iterm_i = 32'h0;
    logic signed [31:0] dterm_i = 32'h0, fterm_i = 32'h0;
    wire cyc_i, stb_i, we_i, ack_o, iacc_clr_o;
    wire [7:0] adr_i;
    wire [3:0] sel_i;
    wire [31:0] dat_i, dat_o;
    wire signed [10:0] out_o;
    wire [1:0] slot_o, mode_o;
    wire [11:0] clramp_o, olramp_o;
    logic [31:0] q;
    int n_mismatch = 0;
    int checks = 0;
    int cyc_n = 0;
    always #5 clk_i = ~clk_i;
    clps_top #(.HOLD_CYC(50)) uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
        .dat_i, .dat_o, .ack_o, .err_i, .pterm_i, .iterm_i, .dterm_i, .fterm_i, .tick_i,
        .out_o, .iacc_clr_o, .slot_o, .mode_o, .clramp_o, .olramp_o);
    clps_ctl_model m (.clk_i, .ack_i(ack_o), .rdat_i(dat_o), .cyc_o(cyc_i), .stb_o(stb_i),
        .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i));
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // profile parameter write by slot and index; read by byte address
    task automatic wp(input logic s, input logic [3:0] p, input logic [31:0] d);
        m.xfer(1'b1, {1'b0, s, p, 2'b00}, 4'hf, d, q);
    endtask
    task automatic rd(input logic [7:0] a);
        m.xfer(1'b0, a, 4'hf, 32'h0, q);
    endtask
    // error presented, then one tick pulse, then settle
    task automatic tk(input logic [31:0] e);
        err_i <= e;
        @(posedge clk_i);
        tick_i <= 1'b1;
        @(posedge clk_i);
        tick_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic rst4;
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic complete_run;
        $display("checks %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // hang guard
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 5000) begin
            n_mismatch++;
            complete_run();
        end
    end
    // main sequence
    initial begin
        rst4();
        rd({2'b00, `CLPS_P_PKFWD, 2'b00});
        chk(q, `CLPS_PKFWD_RST);
        rd({2'b01, `CLPS_P_PKREV, 2'b00});
        chk(q, `CLPS_PKREV_RST);
        m.xfer(1'b1, 8'h9c, 4'hf, 32'hffff_ffff, q);
        rd(8'h9c);
        chk(q, 32'h0);
        m.xfer(1'b1, `CLPS_A_PROF, 4'h1, 32'haabb_ccdd, q);
        rd(`CLPS_A_PROF);
        chk(q, 32'h0000_00dd);
        m.xfer(1'b1, `CLPS_A_CLRAMP, 4'hf, 32'h0000_0abc, q);
        m.xfer(1'b1, `CLPS_A_OLRAMP, 4'h1, 32'h0000_0123, q);
        chk({8'h0, clramp_o, olramp_o}, {8'h0, 12'habc, 12'h023});
        rd(`CLPS_A_OLRAMP);
        chk(q, 32'h0000_0023);
        wp(1'b0, `CLPS_P_PKFWD, 32'h258);
        wp(1'b0, `CLPS_P_PKREV, -32'h258);
        wp(1'b0, `CLPS_P_NMFWD, 32'h64);
        wp(1'b0, `CLPS_P_NMREV, -32'h64);
        wp(1'b0, `CLPS_P_ALLOW, 32'h5);
        wp(1'b0, `CLPS_P_RAMP, 32'h1);
        wp(1'b1, `CLPS_P_PKFWD, 32'hc8);
        foreach (rows[k]) begin
            m.cfg(1'b1, rows[k].m, rows[k].s);
            pterm_i <= rows[k].p;
            iterm_i <= rows[k].p;
            dterm_i <= -rows[k].p;
            fterm_i <= rows[k].f;
            tk(rows[k].e);
            chk({21'h0, out_o}, {21'h0, rows[k].o});
            chk({28'h0, mode_o, slot_o}, {28'h0, rows[k].m, 1'b0, rows[k].s});
        end
        // integral clear by zone, allowable band and disable
        wp(1'b0, `CLPS_P_IZONE, 32'h64);
        m.cfg(1'b1, 2'h1, 1'b0);
        tk(32'h1f4);
        chk(iacc_clr_o, 1'b1);
        tk(32'h32);
        chk(iacc_clr_o, 1'b0);
        tk(32'h2);
        chk(iacc_clr_o, 1'b1);
        m.cfg(1'b0, 2'h1, 1'b0);
        tk(32'h32);
        chk(iacc_clr_o, 1'b1);
        wp(1'b0, `CLPS_P_IZONE, 32'h0);
        m.cfg(1'b1, 2'h1, 1'b0);
        tk(32'h1f4);
        chk(iacc_clr_o, 1'b0);
        // commit timing and reload across reset
        repeat (120) @(posedge clk_i);
        wp(1'b1, `CLPS_P_KP, 32'h11);
        repeat (30) @(posedge clk_i);
        rd(`CLPS_A_STAT);
        chk(q[2], 1'b0);
        wp(1'b1, `CLPS_P_KP, 32'h22);
        rd(`CLPS_A_STAT);
        chk(q[2], 1'b1);
        rst4();
        rd({2'b01, `CLPS_P_KP, 2'b00});
        chk(q, 32'h11);
        rd({2'b00, `CLPS_P_PKFWD, 2'b00});
        chk(q, 32'h258);
        wp(1'b1, `CLPS_P_KP, 32'h22);
        rd({2'b01, `CLPS_P_KP, 2'b00});
        chk(q, 32'h22);
        wp(1'b1, `CLPS_P_KP, 32'h33);
        rd(`CLPS_A_STAT);
        chk(q[3:2], 2'b01);
        repeat (120) @(posedge clk_i);
        rd(`CLPS_A_STAT);
        chk(q[2], 1'b0);
        rst4();
        rd({2'b01, `CLPS_P_KP, 2'b00});
        chk(q, 32'h33);
        complete_run();
    end
endmodule // clps_top_tb
bind clps_top clps_top_props u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .dat_o, .ack_o,
    .tick_i, .out_o, .iacc_clr_o, .slot_o, .mode_o);
